// File: common/tm2_pkg.sv
// Package for the timer block: register map, field positions, reset values and modes
package tm2_pkg;
	// Register byte addresses on the APB
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_MODE1 = 8'h08;
	localparam logic [7:0] ADDR_CNT_LO = 8'h0C;
	localparam logic [7:0] ADDR_CNT_HI = 8'h10;
	localparam logic [7:0] ADDR_RCAP_LO = 8'h14;
	localparam logic [7:0] ADDR_RCAP_HI = 8'h18;
	// Control register bits
	localparam int CTRL_OVF = 7;
	localparam int CTRL_EXT = 6;
	localparam int CTRL_RX_LOWF = 5;
	localparam int CTRL_TX_LOWIE = 4;
	localparam int CTRL_FEE = 3;
	localparam int CTRL_RUN = 2;
	localparam int CTRL_CT = 1;
	localparam int CTRL_CPRL = 0;
	// Mode register bits
	localparam int MODE_SEL_LSB = 0;
	localparam int MODE_SPLIT = 3;
	localparam int MODE_LOW_RUN = 4;
	localparam int MODE_AUTO_STOP = 5;
	localparam int MODE_SCALE_PRIO = 6;
	localparam int MODE_REE = 7;
	// Mode register one bits
	localparam int MODE1_TRIG_LSB = 0;
	localparam int MODE1_IRQ_BLOCK = 3;
	localparam int MODE1_ALT_SEL = 4;
	localparam int MODE1_CLK_SRC = 5;
	localparam int MODE1_CLK_SCALE = 6;
	localparam int MODE1_LOW_CLK = 7;
	// Values after reset and counter maximums
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	localparam logic [15:0] WORD_MAX = 16'hFFFF;
	// Operating modes
	localparam logic [2:0] OPM_RELOAD_INT = 3'h0;
	localparam logic [2:0] OPM_RELOAD = 3'h1;
	localparam logic [2:0] OPM_CAPTURE = 3'h2;
	localparam logic [2:0] OPM_CAPTURE_ZERO = 3'h3;
	localparam logic [2:0] OPM_DUTY = 3'h6;
	typedef enum logic [1:0] {
		DUTY_IDLE,
		DUTY_ARMED,
		DUTY_FIRST,
		DUTY_SECOND
	} tm2_duty_t;
	// Decoded mode register
	typedef struct packed {
		logic rising_edge_enable;
		logic scale_or_prio;
		logic low_run_auto_stop;
		logic low_run_bit;
		logic split_enable;
		logic [2:0] opmode;
	} tm2_mode_t;
	// Decoded mode register one
	typedef struct packed {
		logic low_clk_sel;
		logic clock_scale_select;
		logic clock_source_select;
		logic alternate_bit_select;
		logic overflow_irq_block;
		logic [2:0] trig_sel;
	} tm2_mode1_t;
endpackage

// File: verilog/tm2_timer.sv
// Timer 2 with auto-reload, capture, duty capture and split 8-bit modes, APB slave
`timescale 1ns/1ps
module tm2_timer #(
	parameter int TRIG_N = 8,
	parameter int HCLK_N = 8,
	parameter int LCLK_N = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Count strobes and trigger pins
	input wire logic [HCLK_N-1:0] high_tick_src,
	input wire logic [LCLK_N-1:0] low_tick_src,
	input wire logic [TRIG_N-1:0] trig_in,
	// Interrupt and events
	input wire logic timer_irq_enable,
	output logic timer_irq,
	output logic overflow_event_out,
	output logic low_overflow_event_out,
	// Shared-bit functions
	output logic rx_baud_sel,
	output logic tx_baud_sel,
	output logic interrupt_priority_bit
);
	logic [7:0] mode_raw_r, mode1_raw_r, cnt_hi_r, cnt_lo_r, rcap_hi_r, rcap_lo_r;
	logic [15:0] cnt_nxt, cap_nxt;
	logic [31:0] prdata_r;
	logic [TRIG_N-1:0] sync1_r, sync2_r, sync3_r, trig_lvl_r;
	tm2_pkg::tm2_mode_t mode;
	tm2_pkg::tm2_mode1_t mode1;
	tm2_pkg::tm2_duty_t duty_r, duty_nxt;
	logic overflow_flag_r, external_event_flag_r, low_overflow_flag_r;
	logic low_overflow_irq_enable_r, rx_baud_r, tx_baud_r, low_clock_scale_r, prio_r;
	logic falling_edge_enable_r, high_run_bit_r, ct_sel_r, cprl_r, low_run_bit_r;
	logic sel_prev_r, irq_r, ovf_evt_r, low_evt_r, wr, mapped, alt, selected_trigger_input;
	logic fall_edge, rise_edge, any_edge, ext_evt, hi_tick, lo_tick, cap_load, ovf_set;
	logic ext_set, low_set, run_clr, lowrun_clr, ovf16_evt, low8_evt;

	assign mode = tm2_pkg::tm2_mode_t'({mode_raw_r[7:5], low_run_bit_r, mode_raw_r[3:0]});
	assign mode1 = tm2_pkg::tm2_mode1_t'(mode1_raw_r);
	assign alt = mode1.alternate_bit_select;

	// APB decode; slave never inserts wait states
	assign wr = psel & penable & pwrite;
	always_comb begin
		case (paddr)
			tm2_pkg::ADDR_CTRL, tm2_pkg::ADDR_MODE, tm2_pkg::ADDR_MODE1,
			tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI,
			tm2_pkg::ADDR_RCAP_LO, tm2_pkg::ADDR_RCAP_HI: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_r;

	// Read data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				tm2_pkg::ADDR_CTRL: prdata_r <= {24'h000000, overflow_flag_r,
					external_event_flag_r, alt ? low_overflow_flag_r : rx_baud_r,
					alt ? low_overflow_irq_enable_r : tx_baud_r,
					falling_edge_enable_r, high_run_bit_r, ct_sel_r, cprl_r};
				tm2_pkg::ADDR_MODE: prdata_r <= {24'h000000, mode_raw_r[7],
					alt ? prio_r : low_clock_scale_r, mode_raw_r[5],
					low_run_bit_r, mode_raw_r[3:0]};
				tm2_pkg::ADDR_MODE1: prdata_r <= {24'h000000, mode1_raw_r};
				tm2_pkg::ADDR_CNT_LO: prdata_r <= {24'h000000, cnt_lo_r};
				tm2_pkg::ADDR_CNT_HI: prdata_r <= {24'h000000, cnt_hi_r};
				tm2_pkg::ADDR_RCAP_LO: prdata_r <= {24'h000000, rcap_lo_r};
				tm2_pkg::ADDR_RCAP_HI: prdata_r <= {24'h000000, rcap_hi_r};
				default: prdata_r <= 32'h00000000;
			endcase
		end
	end

	// Trigger pins: three flops, level accepted when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < TRIG_N; gi++) begin : g_trig
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
					trig_lvl_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= trig_in[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					if (sync2_r[gi] == sync3_r[gi]) begin
						trig_lvl_r[gi] <= sync3_r[gi];
					end
				end
			end
		end
	endgenerate

	assign selected_trigger_input = trig_lvl_r[mode1.trig_sel];
	assign fall_edge = sel_prev_r & ~selected_trigger_input;
	assign rise_edge = ~sel_prev_r & selected_trigger_input;
	assign any_edge = fall_edge | rise_edge;
	assign ext_evt = (fall_edge & falling_edge_enable_r) | (rise_edge & mode.rising_edge_enable);

	// eight high clock choices, four low clock choices
	assign hi_tick = high_tick_src[{mode1.clock_scale_select, ct_sel_r, mode1.clock_source_select}];
	assign lo_tick = low_tick_src[{low_clock_scale_r, mode1.low_clk_sel}];

	// Counter, capture, flag and run next-state logic
	always_comb begin
		cnt_nxt = {cnt_hi_r, cnt_lo_r};
		cap_nxt = {rcap_hi_r, rcap_lo_r};
		cap_load = 1'b0;
		ovf_set = 1'b0;
		ext_set = 1'b0;
		low_set = 1'b0;
		run_clr = 1'b0;
		lowrun_clr = 1'b0;
		ovf16_evt = 1'b0;
		low8_evt = 1'b0;
		duty_nxt = duty_r;
		if (mode.split_enable) begin
			duty_nxt = tm2_pkg::DUTY_IDLE;
			// high half on its own run bit
			if (hi_tick & high_run_bit_r) begin
				if (cnt_hi_r == tm2_pkg::BYTE_MAX) begin
					cnt_nxt[15:8] = rcap_hi_r;
					ovf_set = 1'b1;
					lowrun_clr = mode.low_run_auto_stop;
				end else begin
					cnt_nxt[15:8] = cnt_hi_r + 8'h01;
				end
			end
			if (lo_tick & low_run_bit_r) begin
				if (cnt_lo_r == tm2_pkg::BYTE_MAX) begin
					cnt_nxt[7:0] = rcap_lo_r;
					low_set = 1'b1;
					low8_evt = 1'b1;
				end else begin
					cnt_nxt[7:0] = cnt_lo_r + 8'h01;
				end
			end
			if (ext_evt) begin
				ext_set = 1'b1;
				if (mode.opmode == tm2_pkg::OPM_RELOAD) begin
					cnt_nxt = {rcap_hi_r, rcap_lo_r};
				end
			end
		end else if (mode.opmode == tm2_pkg::OPM_DUTY) begin
			case (duty_r)
				tm2_pkg::DUTY_IDLE: begin
					if (high_run_bit_r) begin
						duty_nxt = tm2_pkg::DUTY_ARMED;
					end
				end
				tm2_pkg::DUTY_ARMED: begin
					if (!high_run_bit_r) begin
						duty_nxt = tm2_pkg::DUTY_IDLE;
					end else if (any_edge) begin
						duty_nxt = tm2_pkg::DUTY_FIRST;
					end
				end
				tm2_pkg::DUTY_FIRST: begin
					if (!high_run_bit_r) begin
						duty_nxt = tm2_pkg::DUTY_IDLE;
					end else if (any_edge) begin
						cap_nxt = {cnt_hi_r, cnt_lo_r};
						cap_load = 1'b1;
						ext_set = falling_edge_enable_r;
						duty_nxt = tm2_pkg::DUTY_SECOND;
					end else if (hi_tick) begin
						cnt_nxt = {cnt_hi_r, cnt_lo_r} + 16'h0001;
					end
				end
				tm2_pkg::DUTY_SECOND: begin
					if (!high_run_bit_r) begin
						duty_nxt = tm2_pkg::DUTY_IDLE;
					end else if (any_edge) begin
						run_clr = 1'b1;
						duty_nxt = tm2_pkg::DUTY_IDLE;
					end else if (hi_tick) begin
						cnt_nxt = {cnt_hi_r, cnt_lo_r} + 16'h0001;
					end
				end
				default: duty_nxt = tm2_pkg::DUTY_IDLE;
			endcase
		end else begin
			duty_nxt = tm2_pkg::DUTY_IDLE;
			if (hi_tick & high_run_bit_r) begin
				if ({cnt_hi_r, cnt_lo_r} == tm2_pkg::WORD_MAX) begin
					ovf_set = 1'b1;
					ovf16_evt = 1'b1;
					if (mode.opmode == tm2_pkg::OPM_RELOAD_INT ||
						mode.opmode == tm2_pkg::OPM_RELOAD) begin
						cnt_nxt = {rcap_hi_r, rcap_lo_r};
					end else begin
						cnt_nxt = tm2_pkg::RST_WORD;
					end
				end else begin
					cnt_nxt = {cnt_hi_r, cnt_lo_r} + 16'h0001;
				end
			end
			if (ext_evt) begin
				ext_set = 1'b1;
				case (mode.opmode)
					tm2_pkg::OPM_RELOAD: cnt_nxt = {rcap_hi_r, rcap_lo_r};
					tm2_pkg::OPM_CAPTURE: begin
						cap_nxt = {cnt_hi_r, cnt_lo_r};
						cap_load = 1'b1;
					end
					tm2_pkg::OPM_CAPTURE_ZERO: begin
						cap_nxt = {cnt_hi_r, cnt_lo_r};
						cap_load = 1'b1;
						cnt_nxt = tm2_pkg::RST_WORD;
					end
					default: cnt_nxt = cnt_nxt;
				endcase
			end
		end
	end

	// Count bytes: a software write wins over counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_hi_r <= tm2_pkg::RST_BYTE;
			cnt_lo_r <= tm2_pkg::RST_BYTE;
			duty_r <= tm2_pkg::DUTY_IDLE;
		end else begin
			duty_r <= duty_nxt;
			cnt_hi_r <= (wr && paddr == tm2_pkg::ADDR_CNT_HI) ? pwdata[7:0] : cnt_nxt[15:8];
			cnt_lo_r <= (wr && paddr == tm2_pkg::ADDR_CNT_LO) ? pwdata[7:0] : cnt_nxt[7:0];
		end
	end

	// Reload/capture pair: a hardware capture wins over a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcap_hi_r <= tm2_pkg::RST_BYTE;
			rcap_lo_r <= tm2_pkg::RST_BYTE;
		end else if (cap_load) begin
			rcap_hi_r <= cap_nxt[15:8];
			rcap_lo_r <= cap_nxt[7:0];
		end else if (wr && paddr == tm2_pkg::ADDR_RCAP_HI) begin
			rcap_hi_r <= pwdata[7:0];
		end else if (wr && paddr == tm2_pkg::ADDR_RCAP_LO) begin
			rcap_lo_r <= pwdata[7:0];
		end
	end

	// Control register; flags set by hardware win over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_r <= 1'b0;
			external_event_flag_r <= 1'b0;
			low_overflow_flag_r <= 1'b0;
			low_overflow_irq_enable_r <= 1'b0;
			rx_baud_r <= 1'b0;
			tx_baud_r <= 1'b0;
			falling_edge_enable_r <= 1'b0;
			high_run_bit_r <= 1'b0;
			ct_sel_r <= 1'b0;
			cprl_r <= 1'b0;
		end else begin
			overflow_flag_r <= ovf_set | ((wr && paddr == tm2_pkg::ADDR_CTRL) ?
				pwdata[tm2_pkg::CTRL_OVF] : overflow_flag_r);
			external_event_flag_r <= ext_set | ((wr && paddr == tm2_pkg::ADDR_CTRL) ?
				pwdata[tm2_pkg::CTRL_EXT] : external_event_flag_r);
			low_overflow_flag_r <= low_set | ((wr && paddr == tm2_pkg::ADDR_CTRL && alt) ?
				pwdata[tm2_pkg::CTRL_RX_LOWF] : low_overflow_flag_r);
			if (wr && paddr == tm2_pkg::ADDR_CTRL) begin
				// shared bits routed by alternate select
				if (alt) begin
					low_overflow_irq_enable_r <= pwdata[tm2_pkg::CTRL_TX_LOWIE];
				end else begin
					rx_baud_r <= pwdata[tm2_pkg::CTRL_RX_LOWF];
					tx_baud_r <= pwdata[tm2_pkg::CTRL_TX_LOWIE];
				end
				falling_edge_enable_r <= pwdata[tm2_pkg::CTRL_FEE];
				high_run_bit_r <= pwdata[tm2_pkg::CTRL_RUN];
				ct_sel_r <= pwdata[tm2_pkg::CTRL_CT];
				cprl_r <= pwdata[tm2_pkg::CTRL_CPRL];
			end else if (run_clr) begin
				high_run_bit_r <= 1'b0;
			end
		end
	end

	// Mode registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_raw_r <= tm2_pkg::RST_BYTE;
			mode1_raw_r <= tm2_pkg::RST_BYTE;
			low_run_bit_r <= 1'b0;
			low_clock_scale_r <= 1'b0;
			prio_r <= 1'b0;
		end else begin
			if (wr && paddr == tm2_pkg::ADDR_MODE) begin
				mode_raw_r <= pwdata[7:0];
				low_run_bit_r <= pwdata[tm2_pkg::MODE_LOW_RUN];
				if (alt) begin
					prio_r <= pwdata[tm2_pkg::MODE_SCALE_PRIO];
				end else begin
					low_clock_scale_r <= pwdata[tm2_pkg::MODE_SCALE_PRIO];
				end
			end else if (lowrun_clr) begin
				low_run_bit_r <= 1'b0;
			end
			if (wr && paddr == tm2_pkg::ADDR_MODE1) begin
				mode1_raw_r <= pwdata[7:0];
			end
		end
	end

	// Interrupt request, exported events and trigger level history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_prev_r <= 1'b0;
			irq_r <= 1'b0;
			ovf_evt_r <= 1'b0;
			low_evt_r <= 1'b0;
		end else begin
			sel_prev_r <= selected_trigger_input;
			irq_r <= timer_irq_enable & ((overflow_flag_r & ~mode1.overflow_irq_block) |
				external_event_flag_r | (low_overflow_flag_r & low_overflow_irq_enable_r));
			ovf_evt_r <= mode.split_enable ? low8_evt : ovf16_evt;
			low_evt_r <= low8_evt;
		end
	end
	assign timer_irq = irq_r;
	assign overflow_event_out = ovf_evt_r;
	assign low_overflow_event_out = low_evt_r;
	assign rx_baud_sel = rx_baud_r;
	assign tx_baud_sel = tx_baud_r;
	assign interrupt_priority_bit = prio_r;
endmodule

// File: dv/tm2_apb_master.sv
// APB master model standing in for the processor's register bus
`timescale 1ns/1ps
module tm2_apb_master (
	// Clock
	input wire logic pclk,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released bus never shows the last address or data
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// File: dv/tm2_timer_asserts.sv
// Concurrent checks on the timer block's ports
`timescale 1ns/1ps
module tm2_timer_asserts #(
	parameter int TRIG_N = 8,
	parameter int HCLK_N = 8,
	parameter int LCLK_N = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Count strobes and trigger pins
	input wire logic [HCLK_N-1:0] high_tick_src,
	input wire logic [LCLK_N-1:0] low_tick_src,
	input wire logic [TRIG_N-1:0] trig_in,
	// Interrupt and events
	input wire logic timer_irq_enable,
	input wire logic timer_irq,
	input wire logic overflow_event_out,
	input wire logic low_overflow_event_out,
	// Shared-bit functions
	input wire logic rx_baud_sel,
	input wire logic tx_baud_sel,
	input wire logic interrupt_priority_bit
);
	logic alt_r;
	logic mapped;
	logic any_tick;
	logic low_tick;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= tm2_pkg::ADDR_RCAP_HI);
	assign any_tick = (|high_tick_src) | (|low_tick_src);
	assign low_tick = |low_tick_src;
	// Shared-bit meaning follows the last mode one write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_r <= 1'b0;
		end else if (psel && penable && pwrite && paddr == tm2_pkg::ADDR_MODE1) begin
			alt_r <= pwdata[tm2_pkg::MODE1_ALT_SEL];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_rd_unmapped;
		psel && !penable && !pwrite && !mapped;
	endsequence
	sequence s_ctrl_wr;
		psel && penable && pwrite && paddr == tm2_pkg::ADDR_CTRL && !alt_r;
	endsequence
	sequence s_mode_wr;
		psel && penable && pwrite && paddr == tm2_pkg::ADDR_MODE && alt_r;
	endsequence
	a_ready_high: assert property (s_access |-> pready)
		else $error("pready low in access phase");
	a_err_unmapped: assert property (s_access ##0 !mapped |-> pslverr)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (s_access ##0 mapped |-> !pslverr)
		else $error("error on mapped access");
	a_rd_zero: assert property (s_rd_unmapped |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_ovf_src: assert property (overflow_event_out |-> $past(any_tick, 1))
		else $error("overflow event without count strobe");
	a_low_src: assert property (low_overflow_event_out |-> $past(low_tick, 1))
		else $error("low overflow event without low strobe");
	a_irq_en: assert property (timer_irq |-> $past(timer_irq_enable))
		else $error("interrupt while disabled");
	a_rx_shared: assert property (s_ctrl_wr |-> ##2 (rx_baud_sel == $past(pwdata[5], 2)
		&& tx_baud_sel == $past(pwdata[4], 2)))
		else $error("baud select bits not taken");
	a_prio_shared: assert property (s_mode_wr |-> ##2
		interrupt_priority_bit == $past(pwdata[6], 2))
		else $error("priority bit not taken");
endmodule

// File: dv/tb_timer2_capture_reload_split.sv
// Self-checking bench for the timer block
`timescale 1ns/1ps
module tb_timer2_capture_reload_split;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, f;
	logic irq_en, irq, ovf_ev, low_ev, rx_sel, tx_sel, prio;
	logic [7:0] paddr, htick, ttrig, r, s;
	logic [3:0] ltick;
	logic [31:0] pwdata, prdata, q;
	logic [31:0] exp_q[$];
	string nm_q[$];
	int n_fail, compares, n_ovf, n_low, o0, o1;
	tm2_apb_master u_bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
	tm2_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .high_tick_src(htick), .low_tick_src(ltick), .trig_in(ttrig),
		.timer_irq_enable(irq_en), .timer_irq(irq), .overflow_event_out(ovf_ev),
		.low_overflow_event_out(low_ev), .rx_baud_sel(rx_sel), .tx_baud_sel(tx_sel),
		.interrupt_priority_bit(prio));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_bus.xfer(1'b1, a, {24'h0, d}, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		exp_q.push_back({24'h0, e});
		nm_q.push_back(n);
		u_bus.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic tick(input logic [7:0] h, input logic [3:0] l, input int n);
		repeat (n) begin
			@(posedge pclk);
			htick <= h;
			ltick <= l;
			@(posedge pclk);
			htick <= 8'h00;
			ltick <= 4'h0;
		end
	endtask
	task automatic flip(input int k);
		@(posedge pclk);
		ttrig <= ttrig ^ (8'h01 << k);
		repeat (8) @(posedge pclk);
	endtask
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Read results are compared as they appear on the bus
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			check(nm_q.pop_front(), exp_q.pop_front(), prdata);
		if (ovf_ev === 1'b1) n_ovf++;
		if (low_ev === 1'b1) n_low++;
	end
	initial begin
		#100000;
		n_fail++;
		finish_test();
	end
	initial begin
		presetn = 1'b0;
		htick = 8'h00;
		ltick = 4'h0;
		ttrig = 8'hFF;
		irq_en = 1'b0;
		r = 8'($urandom(32'h8C72));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00, "reset");
		r = 8'($urandom);
		wr(tm2_pkg::ADDR_CTRL, {2'b00, r[1:0], 4'h0});
		rd(tm2_pkg::ADDR_CTRL, {2'b00, r[1:0], 4'h0}, "ctrl");
		check("rx_sel", {31'h0, r[1]}, {31'h0, rx_sel});
		check("tx_sel", {31'h0, r[0]}, {31'h0, tx_sel});
		s = 8'($urandom);
		r = 8'($urandom_range(7));
		wr(tm2_pkg::ADDR_RCAP_LO, s);
		wr(tm2_pkg::ADDR_RCAP_HI, ~s);
		wr(tm2_pkg::ADDR_CNT_LO, 8'hFE);
		wr(tm2_pkg::ADDR_CNT_HI, 8'hFF);
		wr(tm2_pkg::ADDR_MODE, 8'h01);
		wr(tm2_pkg::ADDR_MODE1, {1'b0, r[2], r[0], 5'h00});
		wr(tm2_pkg::ADDR_CTRL, {5'h00, 1'b1, r[1], 1'b0});
		irq_en <= 1'b1;
		tick(~(8'h01 << r), 4'h0, 1);
		tick(8'h01 << r, 4'h0, 2);
		rd(tm2_pkg::ADDR_CTRL, {5'h10, 1'b1, r[1], 1'b0}, "ovf_flag");
		rd(tm2_pkg::ADDR_CNT_LO, s, "reload_lo");
		rd(tm2_pkg::ADDR_CNT_HI, ~s, "reload_hi");
		check("ovf_ev", 1, n_ovf);
		check("irq", 1, {31'h0, irq});
		wr(tm2_pkg::ADDR_MODE1, {1'b0, r[2], r[0], 5'h08});
		repeat (2) @(posedge pclk);
		check("irq_block", 0, {31'h0, irq});
		for (int k = 0; k < 8; k++) begin
			f = ttrig[k];
			wr(tm2_pkg::ADDR_MODE, 8'h01);
			wr(tm2_pkg::ADDR_CTRL, 8'h04);
			wr(tm2_pkg::ADDR_MODE1, 8'(k));
			repeat (8) @(posedge pclk);
			wr(tm2_pkg::ADDR_CNT_HI, 8'h00);
			wr(tm2_pkg::ADDR_MODE, {~f, 6'h00, k[0]});
			wr(tm2_pkg::ADDR_CTRL, {4'h0, f, 3'b100});
			flip((k + 1) % 8);
			rd(tm2_pkg::ADDR_CTRL, {4'h0, f, 3'b100}, "other_pin");
			flip(k);
			rd(tm2_pkg::ADDR_CTRL, {4'h4, f, 3'b100}, "edge_flag");
			rd(tm2_pkg::ADDR_CNT_HI, k[0] ? ~s : 8'h00, "edge_reload");
		end
		for (int m = 2; m < 4; m++) begin
			f = ttrig[7];
			wr(tm2_pkg::ADDR_CTRL, 8'h04);
			wr(tm2_pkg::ADDR_MODE, {~f, 7'(m)});
			wr(tm2_pkg::ADDR_CNT_LO, 8'h10);
			wr(tm2_pkg::ADDR_CNT_HI, 8'h00);
			tick(8'h01, 4'h0, 5);
			wr(tm2_pkg::ADDR_CTRL, {4'h0, f, 3'b100});
			flip(7);
			rd(tm2_pkg::ADDR_CTRL, {4'h4, f, 3'b100}, "cap_flag");
			rd(tm2_pkg::ADDR_RCAP_LO, 8'h15, "cap_lo");
			rd(tm2_pkg::ADDR_CNT_LO, (m == 3) ? 8'h00 : 8'h15, "cnt_after");
		end
		wr(tm2_pkg::ADDR_CTRL, 8'h00);
		wr(tm2_pkg::ADDR_MODE, 8'h00);
		if (ttrig[7]) flip(7);
		wr(tm2_pkg::ADDR_CNT_LO, 8'h00);
		wr(tm2_pkg::ADDR_CNT_HI, 8'h00);
		wr(tm2_pkg::ADDR_MODE, 8'h86);
		wr(tm2_pkg::ADDR_CTRL, 8'h0C);
		tick(8'h01, 4'h0, 2);
		flip(7);
		rd(tm2_pkg::ADDR_CTRL, 8'h0C, "duty_first");
		tick(8'h01, 4'h0, 3);
		flip(7);
		tick(8'h01, 4'h0, 4);
		flip(7);
		tick(8'h01, 4'h0, 2);
		rd(tm2_pkg::ADDR_CNT_LO, 8'h07, "duty_cnt");
		rd(tm2_pkg::ADDR_RCAP_LO, 8'h03, "duty_cap");
		rd(tm2_pkg::ADDR_CTRL, 8'h48, "duty_stop");
		wr(tm2_pkg::ADDR_CTRL, 8'h00);
		wr(tm2_pkg::ADDR_MODE1, 8'h17);
		wr(tm2_pkg::ADDR_RCAP_LO, 8'h40);
		wr(tm2_pkg::ADDR_CNT_LO, 8'hFE);
		wr(tm2_pkg::ADDR_RCAP_HI, 8'h20);
		wr(tm2_pkg::ADDR_CNT_HI, 8'hFF);
		wr(tm2_pkg::ADDR_MODE, 8'h39);
		wr(tm2_pkg::ADDR_CTRL, 8'h04);
		o0 = n_ovf;
		o1 = n_low;
		tick(8'h00, 4'h1, 2);
		rd(tm2_pkg::ADDR_CNT_LO, 8'h40, "lo_reload");
		check("ovf_ev_low", o0 + 1, n_ovf);
		tick(8'h01, 4'h0, 1);
		rd(tm2_pkg::ADDR_CNT_HI, 8'h20, "hi_reload");
		rd(tm2_pkg::ADDR_MODE, 8'h29, "auto_stop");
		rd(tm2_pkg::ADDR_CTRL, 8'hA4, "split_flags");
		check("low_ev", o1 + 1, n_low);
		check("ovf_ev_high", o0 + 1, n_ovf);
		finish_test();
	end
endmodule
bind tm2_timer tm2_timer_asserts #(.TRIG_N(TRIG_N), .HCLK_N(HCLK_N), .LCLK_N(LCLK_N)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.high_tick_src(high_tick_src), .low_tick_src(low_tick_src), .trig_in(trig_in),
	.timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq),
	.overflow_event_out(overflow_event_out), .low_overflow_event_out(low_overflow_event_out),
	.rx_baud_sel(rx_baud_sel), .tx_baud_sel(tx_baud_sel),
	.interrupt_priority_bit(interrupt_priority_bit));
